/* File: common/rx_ovf_pkg.sv */
// shared types and constants for the receive-overflow and bit-clock block
package rx_ovf_pkg;

  localparam int BYTE_BITS = 8;
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_CNT_BYTE_DONE = 4'h8;
  localparam logic [BYTE_BITS-1:0] RX_BUFFER_RESET = 8'h00;

  // bit clocks that the scl low indicator must stand before a stall counts as confirmed
  localparam logic [1:0] STALL_CONFIRM_BITCLKS = 2'h3;
  // main-clock periods beyond which software must read the buffer twice
  localparam int SCL_DOUBLE_READ_MCLKS = 4;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    CLK_SRC_EXT  = 2'h0,
    CLK_SRC_LFXT = 2'h1,
    CLK_SRC_HFXT = 2'h2
  } clk_src_e;

  typedef struct packed {
    logic written;
    logic stalling;
    logic scl_low_indicator;
    logic stall_confirmed;
  } rx_status_s;

  typedef struct packed {
    logic low_freq_crystal_clock;
    logic subsystem_clock;
  } clk_ticks_s;

endpackage

/* File: verilog/sync_2ff.sv */
// two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // the first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= INIT;
      sync_out <= INIT;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // sync_2ff
`default_nettype wire

/* File: verilog/i2c_rx_overflow.sv */
// i2c receive buffer with overflow tracking, clock stretch and bit-clock source select
`timescale 1ns/1ns
`default_nettype none
module i2c_rx_overflow (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  input wire logic ext_bit_clock_in,
  input wire rx_ovf_pkg::clk_ticks_s clk_ticks,
  input wire rx_ovf_pkg::clk_src_e clk_src_sel,
  input wire logic master_mode,
  input wire logic rx_read,
  output logic [rx_ovf_pkg::BYTE_BITS-1:0] rx_buffer,
  output rx_ovf_pkg::rx_status_s rx_status,
  output logic bit_rate_clock,
  output logic clk_src_fault
);
  import rx_ovf_pkg::*;

  logic scl_s;
  logic sda_s;
  logic ext_s;
  logic scl_d_reg;
  logic sda_d_reg;
  logic ext_d_reg;
  logic scl_fall;
  logic scl_rise;
  logic bus_cond;
  logic byte_done;
  logic ext_rise;
  logic [3:0] bit_cnt_reg;
  logic [BYTE_BITS-1:0] shift_reg;
  logic written_reg;
  logic stall_reg;
  logic scl_low_reg;
  logic [1:0] low_cnt_reg;
  logic bit_tick;
  logic ext_blocked;

  sync_2ff #(
    .WIDTH(3),
    .INIT(3'h7)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({scl_in, sda_in, ext_bit_clock_in}),
    .sync_out({scl_s, sda_s, ext_s})
  );

  // edge detection works on the synchronised copies only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      ext_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      ext_d_reg <= ext_s;
    end
  end

  assign scl_fall = scl_d_reg && !scl_s;
  assign scl_rise = !scl_d_reg && scl_s;
  assign ext_rise = !ext_d_reg && ext_s;
  // sda moving while scl stays high is a start or stop
  assign bus_cond = scl_d_reg && scl_s && (sda_d_reg != sda_s);
  assign byte_done = scl_fall && (bit_cnt_reg == BIT_CNT_BYTE_DONE);

  // bit-rate clock source; the external pin is cut off in master mode
  assign ext_blocked = master_mode && (clk_src_sel == CLK_SRC_EXT);

  always_comb begin
    case (clk_src_sel)
      CLK_SRC_EXT: bit_tick = ext_rise && !ext_blocked;
      CLK_SRC_LFXT: bit_tick = clk_ticks.low_freq_crystal_clock;
      CLK_SRC_HFXT: bit_tick = clk_ticks.subsystem_clock;
      default: bit_tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_rate_clock <= 1'b0;
      clk_src_fault <= 1'b0;
    end else begin
      bit_rate_clock <= bit_tick;
      clk_src_fault <= ext_blocked;
    end
  end

  // receive shifter: data sampled on scl rise, ninth clock is the acknowledge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= BIT_CNT_ZERO;
      shift_reg <= RX_BUFFER_RESET;
    end else if (bus_cond) begin
      bit_cnt_reg <= BIT_CNT_ZERO;
    end else if (scl_rise) begin
      if (bit_cnt_reg == BIT_CNT_BYTE_DONE) begin
        bit_cnt_reg <= BIT_CNT_ZERO;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        shift_reg <= {shift_reg[BYTE_BITS-2:0], sda_s};
      end
    end
  end

  // written flag; a stalled byte is moved in when the buffer is read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      written_reg <= 1'b0;
      rx_buffer <= RX_BUFFER_RESET;
    end else if (stall_reg && rx_read) begin
      rx_buffer <= shift_reg;
      written_reg <= 1'b1;
    end else if (byte_done && !written_reg) begin
      rx_buffer <= shift_reg;
      written_reg <= 1'b1;
    end else if (rx_read && !scl_fall) begin
      written_reg <= 1'b0;
    end
    // a read landing on an scl fall changes nothing, the clear is lost
  end

  // overflow: second byte while still written, hold scl low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_reg <= 1'b0;
    end else if (stall_reg && rx_read) begin
      stall_reg <= 1'b0;
    end else if (byte_done && written_reg) begin
      stall_reg <= 1'b1;
    end
  end

  assign scl_oe = stall_reg;
  assign scl_out = 1'b0;

  // low indicator and a saturating count of bit clocks while it stands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_low_reg <= 1'b0;
      low_cnt_reg <= 2'h0;
    end else begin
      scl_low_reg <= !scl_s;
      if (scl_s) begin
        low_cnt_reg <= 2'h0;
      end else if (bit_tick && low_cnt_reg != STALL_CONFIRM_BITCLKS) begin
        low_cnt_reg <= low_cnt_reg + 2'h1;
      end
    end
  end

  // one driver for the whole struct; per-field continuous assigns to one variable are refused
  assign rx_status = '{
    written: written_reg,
    stalling: stall_reg,
    scl_low_indicator: scl_low_reg,
    stall_confirmed: (low_cnt_reg == STALL_CONFIRM_BITCLKS)
  };

  sequence s_overflow;
    byte_done && written_reg && !stall_reg;
  endsequence

  sequence s_fresh_byte;
    byte_done && !written_reg && !stall_reg;
  endsequence

  property p_ext_blocked;
    @(posedge clk) disable iff (!rst_n)
      (master_mode && clk_src_sel == CLK_SRC_EXT) |=> !bit_rate_clock;
  endproperty
  a_ext_blocked: assert property (p_ext_blocked)
    else $error("external bit clock used in master mode");

  property p_fault_flag;
    @(posedge clk) disable iff (!rst_n)
      ext_blocked |=> clk_src_fault;
  endproperty
  a_fault_flag: assert property (p_fault_flag)
    else $error("clock source fault not raised");

  property p_written_set;
    @(posedge clk) disable iff (!rst_n)
      s_fresh_byte |=> written_reg && rx_buffer == $past(shift_reg);
  endproperty
  a_written_set: assert property (p_written_set)
    else $error("completed byte did not set written flag");

  property p_read_clear;
    @(posedge clk) disable iff (!rst_n)
      (rx_read && !scl_fall && !stall_reg && written_reg) |=> !written_reg;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("buffer read did not clear written flag");

  property p_clear_lost;
    @(posedge clk) disable iff (!rst_n)
      (rx_read && scl_fall && written_reg) |=> written_reg;
  endproperty
  a_clear_lost: assert property (p_clear_lost)
    else $error("clear on scl fall was not lost");

  property p_stall_start;
    @(posedge clk) disable iff (!rst_n)
      s_overflow |=> scl_oe && rx_buffer == $past(rx_buffer);
  endproperty
  a_stall_start: assert property (p_stall_start)
    else $error("overflow did not stretch scl");

  property p_stall_hold;
    @(posedge clk) disable iff (!rst_n)
      (s_overflow ##1 !rx_read [*2]) |-> scl_oe;
  endproperty
  a_stall_hold: assert property (p_stall_hold)
    else $error("scl released before buffer read");

  property p_stall_release;
    @(posedge clk) disable iff (!rst_n)
      (stall_reg && rx_read) |=> !scl_oe && written_reg && rx_buffer == $past(shift_reg);
  endproperty
  a_stall_release: assert property (p_stall_release)
    else $error("read during stall mishandled");

  property p_confirm;
    @(posedge clk) disable iff (!rst_n)
      // the count clears one edge after scl returns high, so look at the cycles before
      rx_status.stall_confirmed |-> !$past(scl_s) && !$past(scl_s, 3);
  endproperty
  a_confirm: assert property (p_confirm)
    else $error("stall confirmed without scl held low");

endmodule // i2c_rx_overflow
`default_nettype wire

/* File: dv/i2c_remote_master.sv */
// remote i2c master model: start, eight data bits, ack clock, stop
`timescale 1ns/1ns
`default_nettype none
module i2c_remote_master (
  input wire logic clk,
  input wire logic scl_wire,
  output logic scl_m,
  output logic sda_m
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hp();
    repeat (12) @(posedge clk);
  endtask
  // a released scl may stay low while the receiver stretches; wait, but not forever
  task automatic rise();
    int n;
    n = 0;
    scl_m <= 1'b1;
    @(posedge clk);
    while (scl_wire !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    hp();
  endtask
  task automatic send_byte(input logic [7:0] b);
    sda_m <= 1'b0;
    hp();
    for (int i = 8; i >= 0; i--) begin
      scl_m <= 1'b0;
      hp();
      sda_m <= (i > 0) ? b[(i+7)%8] : 1'b1;
      hp();
      rise();
    end
    scl_m <= 1'b0;
    hp();
    sda_m <= 1'b0;
    hp();
    rise();
    sda_m <= 1'b1;
    hp();
  endtask
endmodule // i2c_remote_master
`default_nettype wire

/* File: dv/i2c_rx_overflow_test.sv */
// bench: receive, overflow stall, lost clear and bit-clock source
`timescale 1ns/1ns
`default_nettype none
module i2c_rx_overflow_test;
  import rx_ovf_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, ext_bit_clock_in = 1'b0, master_mode = 1'b0, rx_read = 1'b0;
  clk_ticks_s clk_ticks = '0;
  clk_src_e clk_src_sel = CLK_SRC_LFXT;
  logic scl_out, scl_oe, bit_rate_clock, clk_src_fault, scl_m, sda_m, scl_wire;
  logic [BYTE_BITS-1:0] rx_buffer;
  rx_status_s rx_status;
  logic [4:0] tick_cnt = '0;
  int miscompares = 0, n_compared = 0, cyc = 0;
  always #4 clk = ~clk;
  always begin
    #62 ext_bit_clock_in = 1'b1;
    #63 ext_bit_clock_in = 1'b0;
  end
  // open drain: the wire is low whenever either side pulls it
  assign scl_wire = scl_m & ~(scl_oe & ~scl_out);
  i2c_remote_master partner_u (.clk, .scl_wire, .scl_m, .sda_m);
  i2c_rx_overflow dut_u (.clk, .rst_n, .scl_in(scl_wire), .scl_out, .scl_oe, .sda_in(sda_m),
    .ext_bit_clock_in, .clk_ticks, .clk_src_sel, .master_mode, .rx_read, .rx_buffer,
    .rx_status, .bit_rate_clock, .clk_src_fault);
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 5'h01;
    clk_ticks.low_freq_crystal_clock <= (tick_cnt[3:0] == 4'h0);
    clk_ticks.subsystem_clock <= (tick_cnt[1:0] == 2'h0);
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input int n);
    rx_read <= 1'b1;
    repeat (n) @(posedge clk);
    rx_read <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_receive();
    partner_u.send_byte(8'hA5);
    check("rx_buffer", rx_buffer, 16'h00A5);
    check("written", rx_status.written, 16'h0001);
    rd(1);
    check("written", rx_status.written, 16'h0000);
    $display("test receive done");
  endtask
  task automatic t_overflow();
    int n;
    n = 0;
    partner_u.send_byte(8'h3C);
    fork
      partner_u.send_byte(8'hC3);
    join_none
    while (rx_status.stall_confirmed !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check("stall_confirmed", rx_status.stall_confirmed, 16'h0001);
    check("scl_oe", scl_oe, 16'h0001);
    check("scl_out", scl_out, 16'h0000);
    check("stalling", rx_status.stalling, 16'h0001);
    check("scl_low_ind", rx_status.scl_low_indicator, 16'h0001);
    check("held byte", rx_buffer, 16'h003C);
    rd(1);
    check("scl_oe", scl_oe, 16'h0000);
    check("rx_buffer", rx_buffer, 16'h00C3);
    check("stalling", rx_status.stalling, 16'h0000);
    check("written", rx_status.written, 16'h0001);
    wait fork;
    rd(1);
    $display("test overflow done");
  endtask
  // sweeps a single read across an scl fall; exactly one offset meets the fall
  task automatic t_lost_clear();
    int lost;
    lost = 0;
    for (int k = 0; k < 8; k++) begin
      partner_u.send_byte(8'h5A);
      partner_u.scl_m <= 1'b0;
      repeat (k) @(posedge clk);
      rd(1);
      repeat (8) @(posedge clk);
      partner_u.scl_m <= 1'b1;
      lost += int'(rx_status.written === 1'b1);
      rd(2);
      check("written", rx_status.written, 16'h0000);
    end
    check("lost clears", 16'(lost), 16'h0001);
    $display("test lost clear done");
  endtask
  // 2000 cycles is a whole number of periods of every tick source
  task automatic t_clock();
    clk_src_e srcs[4] = '{CLK_SRC_EXT, CLK_SRC_LFXT, CLK_SRC_HFXT, CLK_SRC_EXT};
    logic [15:0] want[4] = '{16'h0000, 16'h007D, 16'h01F4, 16'h0080};
    int n;
    for (int m = 0; m < 4; m++) begin
      master_mode <= (m < 3);
      clk_src_sel <= srcs[m];
      repeat (8) @(posedge clk);
      n = 0;
      repeat (2000) begin
        @(posedge clk);
        n += int'(bit_rate_clock === 1'b1);
      end
      check("ticks", 16'(n), want[m]);
      check("fault", clk_src_fault, 16'(m == 0));
    end
    $display("test clock source done");
  endtask
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_receive();
    t_overflow();
    t_lost_clear();
    t_clock();
    complete_run();
  end
endmodule // i2c_rx_overflow_test
`default_nettype wire
